// ---- inc/tes_pkg.sv ----
package tes_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_EVENT_SELECT = 12'h020;
  localparam logic [11:0] OFF_EVENT_BEHAVIOUR = 12'h024;
  localparam logic [11:0] OFF_EXT_INPUT_SELECT = 12'h120;
  localparam logic [11:0] OFF_CAPABILITY_0 = 12'h1e0;
  localparam logic [11:0] OFF_CAPABILITY_1 = 12'h1e4;
  localparam logic [31:0] RW_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Event selection layout
  // ----------------------------------------------------------------
  localparam int NUM_EVENTS = 4;
  localparam int LANE_W = 8;
  localparam int KIND_BIT = 7;
  localparam int CHOICE_W = 4;
  localparam int PAIR_W = 3;
  localparam int NUM_SINGLE = 16;
  localparam int NUM_PAIR = 8;
  localparam logic [31:0] EVENT_SELECT_MASK = 32'h8f8f_8f8f;

  // ----------------------------------------------------------------
  // Event behaviour layout
  // ----------------------------------------------------------------
  localparam logic [31:0] EVENT_BEHAVIOUR_MASK = 32'h0000_180f;
  localparam int ENABLE_LSB = 0;
  localparam int ATB_TRIGGER_BIT = 11;
  localparam int LOW_POWER_KEEP_BIT = 12;

  // ----------------------------------------------------------------
  // External input selection
  // ----------------------------------------------------------------
  localparam int EXT_SEL_W = 8;
  localparam int EXT_BUS_W = 256;

  // ----------------------------------------------------------------
  // Capability register 0 fields
  // ----------------------------------------------------------------
  localparam logic commit_field_meaning = 1'b1;
  localparam logic [4:0] timestamp_width_code = 5'h08;
  localparam logic [1:0] q_element_support = 2'h0;
  localparam logic q_element_filtering = 1'b0;
  localparam logic [1:0] conditional_result_kind = 2'h0;
  localparam logic [1:0] event_count_minus_one = 2'h3;
  localparam logic return_stack_present = 1'b1;
  localparam logic cycle_count_present = 1'b1;
  localparam logic conditional_trace_present = 1'b0;
  localparam logic branch_broadcast_present = 1'b1;
  localparam logic [1:0] data_trace_present = 2'h0;
  localparam logic [1:0] load_store_p0_support = 2'h0;
  localparam logic [31:0] CAPABILITY_0 = {2'h0, commit_field_meaning,
    timestamp_width_code, 7'h00, q_element_support, q_element_filtering,
    conditional_result_kind, event_count_minus_one, return_stack_present,
    1'b0, cycle_count_present, conditional_trace_present,
    branch_broadcast_present, data_trace_present, load_store_p0_support,
    1'b1};

  // ----------------------------------------------------------------
  // Capability register 1 fields
  // ----------------------------------------------------------------
  // Arbitrary neutral identification values
  localparam logic [7:0] code_a = 8'h5a;
  localparam logic [3:0] arch_major_version = 4'h1;
  localparam logic [3:0] arch_minor_version = 4'h1;
  localparam logic [3:0] impl_revision = 4'h1;
  localparam logic [31:0] CAPABILITY_1 = {code_a, 8'h00, 4'hf,
    arch_major_version, arch_minor_version, impl_revision};

endpackage : tes_pkg

// ---- design/tes_event_select.sv ----
// Operation
// - Kind bit clear: four-bit choice picks one of sixteen single resources.
// - Kind bit set: low three bits pick one of eight resource pairs.
// - One control word holds four event bytes: kind bit seven, choice low.
// - Selected events drive the external trace outputs.
// - Per-event enable bit lets an event insert a trace stream element.
// - ATB trigger issued only while the trigger enable bit is set.
// - Override bit keeps resources and event tracing running in low power.
// - Four byte selectors pick external bus events, selector zero lowest.
// - External input resources are offered to the resource selectors.
// - Capability zero reports commit mode one.
// - Capability zero reports timestamp width code for sixty-four bits.
// - Capability zero reports four events as count minus one.
// - Return stack, cycle counting and branch broadcast read as present.
// - Q element, Q filtering and conditional trace fields read zero.
// - Data trace and load/store P0 fields read zero, lowest bit one.
// - Capability one carries code_a code in its top byte.
// - Capability one reports versions and revision, bits 15..12 read ones.
`timescale 1ns/100ps

module tes_event_select (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] single_resource,
  input wire logic [7:0] resource_pair,
  input wire logic [255:0] ext_input_bus,
  input wire logic core_low_power,
  output logic [3:0] ext_trace_out,
  output logic [3:0] event_element,
  output logic atb_trigger,
  output logic [3:0] ext_input_resource
);

  // ----------------------------------------------------------------
  // Event resolution helper
  // ----------------------------------------------------------------
  // Resolve one event byte against the resource selector outputs
  function automatic logic pick_event(
    input logic [7:0] lane,
    input logic [15:0] singles,
    input logic [7:0] pairs
  );
    logic [3:0] choice;
    choice = lane[tes_pkg::CHOICE_W-1:0];
    if (lane[tes_pkg::KIND_BIT]) begin
      pick_event = pairs[choice[tes_pkg::PAIR_W-1:0]];
    end else begin
      pick_event = singles[choice];
    end
  endfunction : pick_event

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] event_select_control;
  logic [31:0] event_behaviour_control;
  logic [31:0] external_input_select;
  logic [31:0] next_event_select_control;
  logic [31:0] next_event_behaviour_control;
  logic [31:0] next_external_input_select;
  logic next_reg_ack;
  logic [31:0] next_reg_rdata;
  logic wr_go;

  assign wr_go = reg_req & reg_write;

  // Write path and read mux
  always_comb begin
    next_event_select_control = event_select_control;
    next_event_behaviour_control = event_behaviour_control;
    next_external_input_select = external_input_select;
    next_reg_ack = reg_req;
    next_reg_rdata = tes_pkg::READ_ZERO;
    if (wr_go) begin
      case (reg_addr)
        tes_pkg::OFF_EVENT_SELECT: begin
          next_event_select_control = reg_wdata &
            tes_pkg::EVENT_SELECT_MASK;
        end
        tes_pkg::OFF_EVENT_BEHAVIOUR: begin
          next_event_behaviour_control = reg_wdata &
            tes_pkg::EVENT_BEHAVIOUR_MASK;
        end
        tes_pkg::OFF_EXT_INPUT_SELECT: begin
          next_external_input_select = reg_wdata;
        end
        default: begin
          next_event_select_control = event_select_control;
        end
      endcase
    end
    if (reg_req && !reg_write) begin
      case (reg_addr)
        tes_pkg::OFF_EVENT_SELECT: begin
          next_reg_rdata = event_select_control;
        end
        tes_pkg::OFF_EVENT_BEHAVIOUR: begin
          next_reg_rdata = event_behaviour_control;
        end
        tes_pkg::OFF_EXT_INPUT_SELECT: begin
          next_reg_rdata = external_input_select;
        end
        tes_pkg::OFF_CAPABILITY_0: begin
          next_reg_rdata = tes_pkg::CAPABILITY_0;
        end
        tes_pkg::OFF_CAPABILITY_1: begin
          next_reg_rdata = tes_pkg::CAPABILITY_1;
        end
        default: begin
          next_reg_rdata = tes_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // Register state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_select_control <= tes_pkg::RW_RESET;
      event_behaviour_control <= tes_pkg::RW_RESET;
      external_input_select <= tes_pkg::RW_RESET;
      reg_ack <= 1'b0;
      reg_rdata <= tes_pkg::READ_ZERO;
    end else begin
      event_select_control <= next_event_select_control;
      event_behaviour_control <= next_event_behaviour_control;
      external_input_select <= next_external_input_select;
      reg_ack <= next_reg_ack;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Event selection and outputs
  // ----------------------------------------------------------------
  logic [3:0] selected;
  logic [3:0] event_enable;
  logic atb_enable;
  logic keep_running;
  logic running;
  logic [3:0] next_ext_trace_out;
  logic [3:0] next_event_element;
  logic next_atb_trigger;
  logic [3:0] next_ext_input_resource;

  assign event_enable = event_behaviour_control[tes_pkg::ENABLE_LSB +:
    tes_pkg::NUM_EVENTS];
  assign atb_enable = event_behaviour_control[tes_pkg::ATB_TRIGGER_BIT];
  assign keep_running = event_behaviour_control[tes_pkg::LOW_POWER_KEEP_BIT];
  // override keeps logic alive in low power
  assign running = !core_low_power || keep_running;

  // Pick each event from its byte of the select word
  always_comb begin
    selected = 4'h0;
    next_ext_input_resource = 4'h0;
    for (int n = 0; n < tes_pkg::NUM_EVENTS; n++) begin
      selected[n] = pick_event(
        event_select_control[n*tes_pkg::LANE_W +: tes_pkg::LANE_W],
        single_resource, resource_pair);
      next_ext_input_resource[n] = running & ext_input_bus[
        external_input_select[n*tes_pkg::EXT_SEL_W +: tes_pkg::EXT_SEL_W]];
    end
  end

  // Next values of the trace side outputs
  always_comb begin
    next_ext_trace_out = running ? selected : 4'h0;
    next_event_element = next_ext_trace_out & event_enable;
    next_atb_trigger = atb_enable & (|next_ext_trace_out);
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_trace_out <= 4'h0;
      event_element <= 4'h0;
      atb_trigger <= 1'b0;
      ext_input_resource <= 4'h0;
    end else begin
      ext_trace_out <= next_ext_trace_out;
      event_element <= next_event_element;
      atb_trigger <= next_atb_trigger;
      ext_input_resource <= next_ext_input_resource;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_clk @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  single_pick_a: assert property (
    (!event_select_control[7] && !core_low_power)
    |=> ext_trace_out[0] == $past(single_resource[event_select_control[3:0]]))
  else $error("event 0 single choice wrong");

  // pair choice uses low three bits
  pair_pick_a: assert property (
    (event_select_control[31] && !core_low_power)
    |=> ext_trace_out[3] == $past(resource_pair[event_select_control[26:24]]))
  else $error("event 3 pair choice wrong");

  select_reserved_a: assert property (
    (event_select_control & ~tes_pkg::EVENT_SELECT_MASK) == 32'h0000_0000)
  else $error("reserved select bits set");

  element_enable_a: assert property (
    event_element[2] |-> ($past(event_behaviour_control[2])
    && ext_trace_out[2]))
  else $error("element without enable");

  trigger_gate_a: assert property (
    atb_trigger |-> ($past(event_behaviour_control[11])
    && ext_trace_out != 4'h0))
  else $error("trigger while disabled");

  // no activity in low power without override
  low_power_quiet_a: assert property (
    (core_low_power && !event_behaviour_control[12])
    |=> (ext_trace_out == 4'h0 && ext_input_resource == 4'h0))
  else $error("activity in low power");

  ext_select_a: assert property (
    !core_low_power |=> ext_input_resource[2] ==
    $past(ext_input_bus[external_input_select[23:16]]))
  else $error("external selector two wrong");

  capability_read_a: assert property (
    (reg_req && !reg_write && reg_addr == tes_pkg::OFF_CAPABILITY_0)
    |=> (reg_ack && reg_rdata == 32'h2800_0ea1))
  else $error("capability zero read wrong");

  ident_ones_a: assert property (
    (reg_req && !reg_write && reg_addr == tes_pkg::OFF_CAPABILITY_1)
    |=> reg_rdata[15:12] == 4'hf)
  else $error("capability one ones missing");

  behaviour_reserved_a: assert property (
    (wr_go && reg_addr == tes_pkg::OFF_EVENT_BEHAVIOUR)
    |=> event_behaviour_control == ($past(reg_wdata) & 32'h0000_180f))
  else $error("reserved behaviour bits stored");

  // Every request answered next cycle
  ack_timing_a: assert property (
    reg_req |=> reg_ack)
  else $error("request not answered");

  // Answer drops one cycle after the request drops
  ack_single_a: assert property (
    !reg_req |=> !reg_ack)
  else $error("answer held too long");

  single_two_a: assert property (
    (!event_select_control[23] && !core_low_power)
    |=> ext_trace_out[2] ==
    $past(single_resource[event_select_control[19:16]]))
  else $error("event 2 single choice wrong");

  pair_one_a: assert property (
    (event_select_control[15] && !core_low_power)
    |=> ext_trace_out[1] ==
    $past(resource_pair[event_select_control[10:8]]))
  else $error("event 1 pair choice wrong");

  trace_three_a: assert property (
    (!event_select_control[31] && !core_low_power)
    |=> ext_trace_out[3] ==
    $past(single_resource[event_select_control[27:24]]))
  else $error("event 3 output wrong");

  element_match_a: assert property (
    event_element ==
    (ext_trace_out & $past(event_behaviour_control[3:0])))
  else $error("element mismatch");

  // enabled trigger fires on any event
  trigger_fire_a: assert property (
    (event_behaviour_control[11] && !core_low_power && selected != 4'h0)
    |=> atb_trigger)
  else $error("enabled trigger missing");

  override_run_a: assert property (
    event_behaviour_control[12] |=> ext_trace_out == $past(selected))
  else $error("override lost events");

  // external resource zero follows its selector
  ext_zero_a: assert property (
    !core_low_power |=> ext_input_resource[0] ==
    $past(ext_input_bus[external_input_select[7:0]]))
  else $error("external selector zero wrong");

  stamp_code_a: assert property (
    (reg_req && !reg_write && reg_addr == tes_pkg::OFF_CAPABILITY_0)
    |=> reg_rdata[28:24] == 5'h08)
  else $error("timestamp code wrong");

  event_count_a: assert property (
    (reg_req && !reg_write && reg_addr == tes_pkg::OFF_CAPABILITY_0)
    |=> reg_rdata[11:10] == 2'h3)
  else $error("event count field wrong");

  present_ones_a: assert property (
    (reg_req && !reg_write && reg_addr == tes_pkg::OFF_CAPABILITY_0)
    |=> (reg_rdata[9] && reg_rdata[7] && reg_rdata[5]))
  else $error("present feature bits wrong");

  absent_zero_a: assert property (
    (reg_req && !reg_write && reg_addr == tes_pkg::OFF_CAPABILITY_0)
    |=> (reg_rdata[16:12] == 5'h00 && reg_rdata[6] == 1'b0
    && reg_rdata[4:1] == 4'h0 && reg_rdata[0] == 1'b1))
  else $error("absent feature fields wrong");

  code_a_code_a: assert property (
    (reg_req && !reg_write && reg_addr == tes_pkg::OFF_CAPABILITY_1)
    |=> reg_rdata[31:24] == tes_pkg::code_a)
  else $error("code_a code wrong");

  select_masked_a: assert property (
    (wr_go && reg_addr == tes_pkg::OFF_EVENT_SELECT)
    |=> event_select_control == ($past(reg_wdata) & 32'h8f8f_8f8f))
  else $error("reserved select bits stored");

endmodule : tes_event_select

// ---- bench/tes_debugger_model.sv ----
`timescale 1ns/100ps

// ------------------------------------------------------------
// Debugger model: single-word register accesses
// ------------------------------------------------------------
module tes_debugger_model (
  input wire logic core_clk,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  output logic reg_req,
  output logic reg_write,
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata
);
  // Idle bus at time zero
  initial begin
    reg_req = 1'b0;
    reg_write = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
  end

  // One-cycle request, then a bounded wait for the answer
  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic ok);
    int i;
    @(posedge core_clk);
    #1;
    reg_req = 1'b1;
    reg_write = wr;
    reg_addr = addr;
    reg_wdata = wdata;
    @(posedge core_clk);
    #1;
    reg_req = 1'b0;
    // Released lines show the inverse, never a stale copy
    reg_write = ~wr;
    reg_addr = ~addr;
    reg_wdata = ~wdata;
    ok = 1'b0;
    for (i = 0; i < 4 && ok == 1'b0; i++) begin
      if (reg_ack === 1'b1) begin
        ok = 1'b1;
      end else begin
        @(posedge core_clk);
        #1;
      end
    end
    rdata = reg_rdata;
  endtask : xfer
endmodule : tes_debugger_model

// ---- bench/tb_tes_event_select.sv ----
`timescale 1ns/100ps

module tb_tes_event_select;
  logic core_clk, rst_n, reg_req, reg_write, reg_ack;
  logic core_low_power, atb_trigger;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, word;
  logic [15:0] single_resource;
  logic [7:0] resource_pair;
  logic [255:0] ext_input_bus;
  logic [3:0] ext_trace_out, event_element, ext_input_resource;
  int err_count = 0;
  int n_tests = 0;
  int s, n;

  tes_event_select tes_event_select_inst (.core_clk(core_clk),
    .rst_n(rst_n), .reg_req(reg_req), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .single_resource(single_resource),
    .resource_pair(resource_pair), .ext_input_bus(ext_input_bus),
    .core_low_power(core_low_power), .ext_trace_out(ext_trace_out),
    .event_element(event_element), .atb_trigger(atb_trigger),
    .ext_input_resource(ext_input_resource));

  tes_debugger_model tes_debugger_model_inst (.core_clk(core_clk),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      err_count++;
      $display("MISMATCH %0t: got %h want %h", $time, got, want);
    end
  endtask : cmp

  task automatic acc(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    logic ok;
    tes_debugger_model_inst.xfer(wr, a, d, rd, ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t: no acknowledge", $time);
      tally_and_finish();
    end
  endtask : acc

  task automatic rdc(input logic [11:0] a, input logic [31:0] want);
    acc(1'b0, a, 32'h0000_0000);
    cmp(rd, want);
  endtask : rdc

  // Expected {trace, element, trigger, ext resource} after settling
  task automatic outc(input logic [12:0] want);
    repeat (2) @(posedge core_clk);
    #1;
    cmp({19'h0, ext_trace_out, event_element, atb_trigger,
         ext_input_resource}, {19'h0, want});
  endtask : outc

  // Clock at 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    single_resource = 16'h0000;
    resource_pair = 8'h00;
    ext_input_bus = '0;
    core_low_power = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    // Controls start at zero after reset
    rdc(tes_pkg::OFF_EVENT_SELECT, 32'h0000_0000);
    rdc(tes_pkg::OFF_EVENT_BEHAVIOUR, 32'h0000_0000);
    rdc(tes_pkg::OFF_EXT_INPUT_SELECT, 32'h0000_0000);
    rdc(tes_pkg::OFF_CAPABILITY_0, (32'h1 << 29) | (32'h08 << 24) |
        (32'h3 << 10) | (32'h1 << 9) | (32'h1 << 7) | (32'h1 << 5) |
        32'h1);
    acc(1'b1, tes_pkg::OFF_CAPABILITY_1, 32'h0000_0000);
    rdc(tes_pkg::OFF_CAPABILITY_1, {tes_pkg::code_a, 8'h00, 4'hf,
        tes_pkg::arch_major_version, tes_pkg::arch_minor_version,
        tes_pkg::impl_revision});
    acc(1'b1, 12'h100, 32'hffff_ffff);
    rdc(12'h100, 32'h0000_0000);
    acc(1'b1, tes_pkg::OFF_EVENT_SELECT, 32'hffff_ffff);
    rdc(tes_pkg::OFF_EVENT_SELECT, 32'h8f8f_8f8f);
    acc(1'b1, tes_pkg::OFF_EVENT_BEHAVIOUR, 32'hffff_ffff);
    rdc(tes_pkg::OFF_EVENT_BEHAVIOUR, 32'h0000_180f);
    acc(1'b1, tes_pkg::OFF_EXT_INPUT_SELECT, 32'hffff_ffff);
    rdc(tes_pkg::OFF_EXT_INPUT_SELECT, 32'hffff_ffff);
    // single resource choice per event lane
    for (s = 0; s < 16; s++) begin
      for (n = 0; n < 4; n++) word[8*n +: 8] = {4'h7, 4'((s + n) & 15)};
      acc(1'b1, tes_pkg::OFF_EVENT_SELECT, word);
      resource_pair = 8'hff;
      single_resource = 16'h1 << s;
      outc({4'b0001, 4'b0001, 1'b1, 4'b0000});
      single_resource = ~(16'h1 << s);
      outc({4'b1110, 4'b1110, 1'b1, 4'b0000});
    end
    // pair choice uses only the low three bits
    for (s = 0; s < 8; s++) begin
      for (n = 0; n < 4; n++) word[8*n +: 8] = {5'h19, 3'((s + n) & 7)};
      acc(1'b1, tes_pkg::OFF_EVENT_SELECT, word);
      single_resource = 16'hffff;
      resource_pair = 8'h1 << s;
      outc({4'b0001, 4'b0001, 1'b1, 4'b0000});
      resource_pair = ~(8'h1 << s);
      outc({4'b1110, 4'b1110, 1'b1, 4'b0000});
    end
    acc(1'b1, tes_pkg::OFF_EVENT_SELECT, 32'h0000_0000);
    single_resource = 16'h0001;
    acc(1'b1, tes_pkg::OFF_EVENT_BEHAVIOUR, 32'h0000_000a);
    outc({4'b1111, 4'b1010, 1'b0, 4'b0000});
    acc(1'b1, tes_pkg::OFF_EVENT_BEHAVIOUR, 32'h0000_0805);
    outc({4'b1111, 4'b0101, 1'b1, 4'b0000});
    single_resource = 16'h0000;
    outc({4'b0000, 4'b0000, 1'b0, 4'b0000});
    // low-power override, external inputs active too
    single_resource = 16'h0001;
    ext_input_bus[255] = 1'b1;
    core_low_power = 1'b1;
    outc(13'h0000);
    acc(1'b1, tes_pkg::OFF_EVENT_BEHAVIOUR, 32'hffff_f7ff);
    outc({4'b1111, 4'b1111, 1'b0, 4'b1111});
    core_low_power = 1'b0;
    acc(1'b1, tes_pkg::OFF_EVENT_BEHAVIOUR, 32'h0000_180f);
    word = 32'hff80_0100;
    acc(1'b1, tes_pkg::OFF_EXT_INPUT_SELECT, word);
    for (n = 0; n < 4; n++) begin
      ext_input_bus = '0;
      ext_input_bus[word[8*n +: 8]] = 1'b1;
      outc({4'b1111, 4'b1111, 1'b1, 4'(1 << n)});
    end
    // Mid-run reset returns every control to zero
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    outc({4'b1111, 4'b0000, 1'b0, 4'b0000});
    rdc(tes_pkg::OFF_EVENT_BEHAVIOUR, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : tb_tes_event_select
